// File: include/cdpic_consts.svh
// register offsets, field positions and reset values of the dual interrupt controller
`ifndef CDPIC_CONSTS_SVH
`define CDPIC_CONSTS_SVH
`define CDPIC_OFS_XBCFG 8'h00
`define CDPIC_OFS_LVL 8'h04
`define CDPIC_OFS_MASK 8'h08
`define CDPIC_OFS_STEER 8'h0c
`define CDPIC_OFS_MCFG 8'h10
`define CDPIC_OFS_SCFG 8'h14
`define CDPIC_OFS_IRR 8'h18
`define CDPIC_OFS_ISR 8'h1c
`define CDPIC_OFS_EOI 8'h20
`define CDPIC_OFS_ISTAT 8'h24
`define CDPIC_OFS_ICLR 8'h28
`define CDPIC_OFS_IEN 8'h2c
`define CDPIC_BIT_APIC 0
`define CDPIC_BIT_MOUSE 4
`define CDPIC_BIT_AEOI 0
`define CDPIC_BIT_SFNM 1
`define CDPIC_BIT_STEN 7
`define CDPIC_LVL_WMASK 16'hdff8
`define CDPIC_EXT_MASK 16'hcffa
`define CDPIC_STEER_OK 16'hdef8
`define CDPIC_RST_MASK 16'hffff
`define CDPIC_RST_MCFG 8'h08
`define CDPIC_RST_SCFG 8'h70
`define CDPIC_CASC_LINE 3'h2
`define CDPIC_SPUR_ID 3'h7
`define CDPIC_EV_ACK 0
`define CDPIC_EV_SPUR 1
`define CDPIC_EV_SLV 2
`endif

// File: include/cdpic_pkg.sv
// types and shared helpers of the dual interrupt controller
package cdpic_pkg;
    typedef logic [7:0] cdpic_line8_t;
    typedef logic [3:0] cdpic_hit_t;
    // lowest set bit: {found, index}; lowest index wins priority
    function automatic cdpic_hit_t cdpic_lowest(input cdpic_line8_t v);
        cdpic_hit_t r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
                r = {1'b1, 3'(i)};
        end
        return r;
    endfunction
endpackage

// File: include/cdpic_core_if.sv
// link between the controller top and one priority core
`timescale 1ns/1ps
`default_nettype none
interface cdpic_core_if;
    logic [7:0] req;
    logic [7:0] lvl;
    logic [7:0] mask;
    logic aeoi;
    logic sfnm;
    logic ack;
    logic eoi;
    logic intOut;
    logic [2:0] vecId;
    logic [7:0] irr;
    logic [7:0] isr;
    modport core (input req, lvl, mask, aeoi, sfnm, ack, eoi,
                  output intOut, vecId, irr, isr);
    modport ctl (output req, lvl, mask, aeoi, sfnm, ack, eoi,
                 input intOut, vecId, irr, isr);
endinterface
`default_nettype wire

// File: hdl/cdpic_core.sv
// one eight-line priority core with request, in-service and nesting logic
`timescale 1ns/1ps
`default_nettype none
module cdpic_core
    import cdpic_pkg::*;
(
    input wire logic clock,
    input wire logic rstSync,
    cdpic_core_if.core bus
);
    logic [7:0] prevReq;
    logic [7:0] irr;
    logic [7:0] isr;
    logic [7:0] pend;
    cdpic_hit_t pHit;
    cdpic_hit_t sHit;

    // lower index ranks higher; in-service blocks lower levels, and equal ones unless sfnm is set
    assign pend = irr & ~bus.mask;
    assign pHit = cdpic_lowest(pend);
    assign sHit = cdpic_lowest(isr);
    assign bus.intOut = pHit[3] && (!sHit[3] || pHit[2:0] < sHit[2:0]
                        || (bus.sfnm && pHit[2:0] == sHit[2:0]));
    assign bus.vecId = pHit[2:0];
    assign bus.irr = irr;
    assign bus.isr = isr;

    // request latch: edge mode sets on a rise, level mode follows the line
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            prevReq <= 8'h00;
            irr <= 8'h00;
        end
        else
        begin
            prevReq <= bus.req;
            for (int i = 0; i < 8; i++)
            begin
                if (bus.lvl[i])
                    irr[i] <= bus.req[i];
                else if (bus.req[i] && !prevReq[i])
                    irr[i] <= 1'b1; // a new edge beats the ack clear
                else if (bus.ack && bus.vecId == 3'(i))
                    irr[i] <= 1'b0;
            end
        end
    end

    // in-service: set on ack unless auto-eoi, non-specific eoi clears the top one
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            isr <= 8'h00;
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (bus.ack && !bus.aeoi && bus.vecId == 3'(i))
                    isr[i] <= 1'b1;
                else if (bus.eoi && sHit[3] && sHit[2:0] == 3'(i))
                    isr[i] <= 1'b0;
            end
        end
    end

    prio_low_a: assert property (@(posedge clock) disable iff (!rstSync)
        pend[0] |-> bus.vecId == 3'h0)
        else $error("line 0 pending but not chosen");
endmodule
`default_nettype wire

// File: hdl/cdpic_top.sv
// cascaded dual interrupt controller with pci steering and apb registers
//
// Functional notes
// - two cores: master lines 7-0, slave 15-8
// - first core master, second core slave
// - master line 2 carries slave cascade only
// - thirteen external lines plus three internal lines
// - line 0 driven by timer counter 0
// - line 0 external only with apic enabled
// - line 13 from internal coprocessor error
// - line 1 always edge triggered
// - lines 15,14,12-3 edge or level programmable
// - four pci lines steer to eleven lines
// - cores configured independently, own modes
// - reset: edge, normal eoi, nesting off, cascade
// - mouse select bit 4 sources line 12
`timescale 1ns/1ps
`default_nettype none
`include "cdpic_consts.svh"
module cdpic_top
    import cdpic_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] extIrq,
    input wire logic [3:0] pciIrqN,
    input wire logic timerIrq,
    input wire logic fpuErrIrq,
    input wire logic mouseIrq,
    output logic intr,
    input wire logic inta,
    output logic [7:0] vector,
    output logic vectorValid,
    output logic irq
);
    logic [1:0] rstPipe;
    logic rstSync;
    logic [7:0] busChipSelectConfig;
    logic [15:0] levelSel;
    logic [15:0] irqMask;
    logic [31:0] steerCfg;
    logic [7:0] mstCfg;
    logic [7:0] slvCfg;
    logic [2:0] intStat;
    logic [2:0] intEn;
    logic [15:0] steerHit;
    logic [15:0] lineReq;
    logic [2:0] events;
    logic apicEn;
    logic mouseSel;
    logic wrEn;
    logic rdEn;
    logic mapped;
    logic mstAck;
    logic slvAck;
    logic [31:0] next_prdata;

    cdpic_core_if mstIf ();
    cdpic_core_if slvIf ();

    // reset released through two flops so every core leaves reset on one edge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rstPipe <= 2'h0;
        else
            rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstSync = rstPipe[1];

    // apb decode: zero wait states, unmapped offsets answer with pslverr
    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    always_comb
    begin
        case (paddr)
            `CDPIC_OFS_XBCFG, `CDPIC_OFS_LVL, `CDPIC_OFS_MASK, `CDPIC_OFS_STEER,
            `CDPIC_OFS_MCFG, `CDPIC_OFS_SCFG, `CDPIC_OFS_IRR, `CDPIC_OFS_ISR,
            `CDPIC_OFS_EOI, `CDPIC_OFS_ISTAT, `CDPIC_OFS_ICLR, `CDPIC_OFS_IEN:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;
    assign apicEn = busChipSelectConfig[`CDPIC_BIT_APIC];
    assign mouseSel = busChipSelectConfig[`CDPIC_BIT_MOUSE];

    // system configuration: apic enable and mouse line select
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            busChipSelectConfig <= 8'h00;
        else if (wrEn && paddr == `CDPIC_OFS_XBCFG)
            busChipSelectConfig <= pwdata[7:0] & 8'h11;
    end

    // trigger sense: lines 0,1,2,13 stay edge whatever software writes
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            levelSel <= 16'h0000; // all edge after reset
        else if (wrEn && paddr == `CDPIC_OFS_LVL)
            levelSel <= pwdata[15:0] & `CDPIC_LVL_WMASK;
    end

    // line masks; everything masked until software opens lines
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            irqMask <= `CDPIC_RST_MASK;
        else if (wrEn && paddr == `CDPIC_OFS_MASK)
            irqMask <= pwdata[15:0];
    end

    // steering: one byte per pci line, enable in bit 7, target in bits 3:0
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            steerCfg <= 32'h00000000;
        else if (wrEn && paddr == `CDPIC_OFS_STEER)
            steerCfg <= pwdata & 32'h8f8f8f8f;
    end

    // per-core mode words, written separately so the cores may differ
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            mstCfg <= `CDPIC_RST_MCFG; // normal eoi, nesting off
            slvCfg <= `CDPIC_RST_SCFG;
        end
        else
        begin
            if (wrEn && paddr == `CDPIC_OFS_MCFG)
                mstCfg <= pwdata[7:0] & 8'hfb;
            if (wrEn && paddr == `CDPIC_OFS_SCFG)
                slvCfg <= pwdata[7:0] & 8'hfb;
        end
    end

    // steering decode; targets outside the allowed eleven never hit
    always_comb
    begin
        steerHit = 16'h0000;
        for (int i = 0; i < 4; i++)
        begin
            if (steerCfg[8 * i + `CDPIC_BIT_STEN] && !pciIrqN[i])
                steerHit[steerCfg[8 * i +: 4]] = 1'b1;
        end
        steerHit = steerHit & `CDPIC_STEER_OK;
    end

    // line sources: external pins, steering and the internal functions
    always_comb
    begin
        lineReq = (extIrq & `CDPIC_EXT_MASK) | steerHit;
        lineReq[0] = apicEn ? extIrq[0] : timerIrq;
        lineReq[2] = slvIf.intOut; // cascade input only
        lineReq[12] = (mouseSel ? mouseIrq : extIrq[12]) | steerHit[12];
        lineReq[13] = fpuErrIrq; // internal only
    end

    // master takes lines 7-0, slave 15-8
    assign mstIf.req = lineReq[7:0];
    assign slvIf.req = lineReq[15:8];
    assign mstIf.lvl = levelSel[7:0];
    assign slvIf.lvl = levelSel[15:8];
    assign mstIf.mask = irqMask[7:0];
    assign slvIf.mask = irqMask[15:8];
    assign mstIf.aeoi = mstCfg[`CDPIC_BIT_AEOI];
    assign slvIf.aeoi = slvCfg[`CDPIC_BIT_AEOI];
    assign mstIf.sfnm = mstCfg[`CDPIC_BIT_SFNM];
    assign slvIf.sfnm = slvCfg[`CDPIC_BIT_SFNM];
    assign mstIf.eoi = wrEn && paddr == `CDPIC_OFS_EOI && pwdata[0];
    assign slvIf.eoi = wrEn && paddr == `CDPIC_OFS_EOI && pwdata[1];

    // acknowledge: slave answers when the master picked its cascade line
    assign mstAck = inta && mstIf.intOut;
    assign slvAck = mstAck && mstIf.vecId == `CDPIC_CASC_LINE;
    assign mstIf.ack = mstAck;
    assign slvIf.ack = slvAck;
    assign intr = mstIf.intOut;

    cdpic_core u_master (
        .clock(clock),
        .rstSync(rstSync),
        .bus(mstIf)
    );

    cdpic_core u_slave (
        .clock(clock),
        .rstSync(rstSync),
        .bus(slvIf)
    );

    // vector capture; a vanished request gives the spurious code of the core
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            vector <= 8'h00;
            vectorValid <= 1'b0;
        end
        else
        begin
            vectorValid <= inta;
            if (inta)
            begin
                if (!mstIf.intOut)
                    vector <= {mstCfg[7:3], `CDPIC_SPUR_ID};
                else if (slvAck && slvIf.intOut)
                    vector <= {slvCfg[7:3], slvIf.vecId};
                else if (slvAck)
                    vector <= {slvCfg[7:3], `CDPIC_SPUR_ID};
                else
                    vector <= {mstCfg[7:3], mstIf.vecId};
            end
        end
    end

    // status events raised by the acknowledge cycle
    always_comb
    begin
        events = 3'h0;
        events[`CDPIC_EV_ACK] = mstAck;
        events[`CDPIC_EV_SPUR] = inta && (!mstIf.intOut || (slvAck && !slvIf.intOut));
        events[`CDPIC_EV_SLV] = slvAck;
    end

    // sticky status: an event in the clearing cycle survives the clear
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            intStat <= 3'h0;
            intEn <= 3'h0;
        end
        else
        begin
            if (wrEn && paddr == `CDPIC_OFS_ICLR)
                intStat <= (intStat & ~pwdata[2:0]) | events;
            else
                intStat <= intStat | events;
            if (wrEn && paddr == `CDPIC_OFS_IEN)
                intEn <= pwdata[2:0];
        end
    end
    assign irq = |(intStat & intEn);

    // read mux; sampled in setup so prdata comes from a flop in access
    always_comb
    begin
        case (paddr)
            `CDPIC_OFS_XBCFG: next_prdata = {24'h000000, busChipSelectConfig};
            `CDPIC_OFS_LVL: next_prdata = {16'h0000, levelSel};
            `CDPIC_OFS_MASK: next_prdata = {16'h0000, irqMask};
            `CDPIC_OFS_STEER: next_prdata = steerCfg;
            `CDPIC_OFS_MCFG: next_prdata = {24'h000000, mstCfg};
            `CDPIC_OFS_SCFG: next_prdata = {24'h000000, slvCfg};
            `CDPIC_OFS_IRR: next_prdata = {16'h0000, slvIf.irr, mstIf.irr};
            `CDPIC_OFS_ISR: next_prdata = {16'h0000, slvIf.isr, mstIf.isr};
            `CDPIC_OFS_ISTAT: next_prdata = {29'h00000000, intStat};
            `CDPIC_OFS_IEN: next_prdata = {29'h00000000, intEn};
            default: next_prdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            prdata <= 32'h00000000;
        else if (rdEn)
            prdata <= next_prdata;
    end

    // checks and coverage
    line0_timer_a: assert property (@(posedge clock) disable iff (!rstSync)
        !apicEn |-> mstIf.req[0] == timerIrq)
        else $error("line 0 not fed by timer");

    line0_apic_a: assert property (@(posedge clock) disable iff (!rstSync)
        apicEn |-> mstIf.req[0] == extIrq[0])
        else $error("line 0 not external with apic on");

    cascade_in_a: assert property (@(posedge clock) disable iff (!rstSync)
        $rose(slvIf.intOut) && !mstIf.irr[2] && !mstIf.lvl[2] |=> mstIf.irr[2])
        else $error("slave request not latched at master line 2");

    fpu_line_a: assert property (@(posedge clock) disable iff (!rstSync)
        $rose(fpuErrIrq) |=> slvIf.irr[5])
        else $error("coprocessor error not seen on line 13");

    edge_fixed_a: assert property (@(posedge clock) disable iff (!rstSync)
        levelSel[2:0] == 3'h0 && !levelSel[13])
        else $error("fixed edge line became level");

    level_prog_a: assert property (@(posedge clock) disable iff (!rstSync)
        wrEn && paddr == `CDPIC_OFS_LVL |=> levelSel == ($past(pwdata[15:0]) & 16'hdff8))
        else $error("trigger sense write lost");

    steer_bad_a: assert property (@(posedge clock) disable iff (!rstSync)
        (steerHit & ~16'hdef8) == 16'h0000)
        else $error("pci line steered to forbidden line");

    mouse_src_a: assert property (@(posedge clock) disable iff (!rstSync)
        mouseSel && !steerHit[12] |-> slvIf.req[4] == mouseIrq)
        else $error("line 12 not from mouse logic");

    cfg_indep_a: assert property (@(posedge clock) disable iff (!rstSync)
        wrEn && paddr == `CDPIC_OFS_MCFG |=> $stable(slvCfg))
        else $error("master mode write touched slave");

    reset_dflt_a: assert property (@(posedge clock)
        $rose(rstSync) |-> levelSel == 16'h0000 && !mstCfg[0] && !slvCfg[1])
        else $error("reset defaults wrong");

    slave_vec_a: assert property (@(posedge clock) disable iff (!rstSync)
        slvAck && slvIf.intOut |=> vectorValid && vector[7:3] == $past(slvCfg[7:3]))
        else $error("cascade ack not answered by slave vector");

    casc_rank_a: assert property (@(posedge clock) disable iff (!rstSync)
        mstIf.intOut && mstIf.irr[1] && !mstIf.mask[1] && !mstIf.isr[1]
        && !mstIf.isr[0] |-> mstIf.vecId <= 3'h1)
        else $error("slave group outranked line 1");

    slave_ack_c: cover property (@(posedge clock) disable iff (!rstSync)
        slvAck ##1 vectorValid);
    spurious_c: cover property (@(posedge clock) disable iff (!rstSync)
        events[`CDPIC_EV_SPUR]);
    steer_hit_c: cover property (@(posedge clock) disable iff (!rstSync)
        |steerHit ##1 intr);
    level_line_c: cover property (@(posedge clock) disable iff (!rstSync)
        |(levelSel & lineReq) ##1 irq);
endmodule
`default_nettype wire

// File: sim/cdpic_cpu_model.sv
// behavioural processor that takes interrupts from the controller and acknowledges them
`timescale 1ns/1ps
`default_nettype none
module cdpic_cpu_model
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic intr,
    input wire logic vectorValid,
    input wire logic [7:0] vector,
    input wire logic ackEn,
    input wire logic forceAck,
    input wire logic slow,
    output logic inta,
    output logic [7:0] lastVector,
    output logic [7:0] vecCount
);
    // one acknowledge at a time; a gap cycle keeps pulses apart
    initial
    begin
        inta = 1'b0;
        lastVector = 8'h00;
        vecCount = 8'h00;
        forever
        begin
            @(posedge clock);
            if (rst_n === 1'b1 && ackEn === 1'b1 && (intr === 1'b1 || forceAck === 1'b1))
            begin
                // a slow cpu still finishes an ack it has begun, like a real one
                repeat (slow ? 3 : 0) @(posedge clock);
                inta <= 1'b1;
                @(posedge clock);
                inta <= 1'b0;
                @(posedge clock);
                // vector counted only when it comes in the cycle after the ack
                if (vectorValid === 1'b1)
                begin
                    lastVector <= vector;
                    vecCount <= vecCount + 8'h01;
                end
                @(posedge clock);
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_cascaded_dual_pic_with_steering.sv
// self-checking bench of the cascaded dual interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "cdpic_consts.svh"
`define CHECK_EQ(got, exp) \
begin samplesChecked++; if ((got) !== (exp)) begin badCount++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_cascaded_dual_pic_with_steering;
    logic clock = 1'b0;
    logic rst_n, psel, penable, pwrite, timerIrq, fpuErrIrq, mouseIrq;
    logic ackEn, forceAck, slow, pready, pslverr, intr, inta, vectorValid, irq, err;
    logic [7:0] paddr, vector, lastVector, vecCount, seenCount;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] extIrq;
    logic [3:0] pciIrqN;
    logic [3:0] tgts [11] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
    int badCount = 0;
    int samplesChecked = 0;

    always #50 clock = ~clock;

    cdpic_top i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extIrq(extIrq), .pciIrqN(pciIrqN), .timerIrq(timerIrq),
        .fpuErrIrq(fpuErrIrq), .mouseIrq(mouseIrq), .intr(intr), .inta(inta),
        .vector(vector), .vectorValid(vectorValid), .irq(irq));
    cdpic_cpu_model i_cpu (.clock(clock), .rst_n(rst_n), .intr(intr),
        .vectorValid(vectorValid), .vector(vector), .ackEn(ackEn), .forceAck(forceAck),
        .slow(slow), .inta(inta), .lastVector(lastVector), .vecCount(vecCount));

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHECK_EQ(pready, 1'b1) // a wait that runs out counts as a mismatch
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHECK_EQ(rd, exp)
    endtask

    // wait for the next vector taken by the cpu, compare it, then end the service unless eoi is zero
    task automatic expv(input logic [7:0] exp, input logic [1:0] eoi);
        int n;
        n = 0;
        while (vecCount === seenCount && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        seenCount = vecCount;
        `CHECK_EQ(n < 100, 1'b1)
        `CHECK_EQ(lastVector, exp)
        if (eoi != 2'h0)
            apb(1'b1, `CDPIC_OFS_EOI, {30'h0, eoi});
    endtask

    // an ignored source must leave the cpu untouched
    task automatic quiet();
        repeat (6) @(posedge clock);
        `CHECK_EQ(intr, 1'b0)
        `CHECK_EQ(vecCount, seenCount)
    endtask

    task automatic t_reset();
        rdchk(`CDPIC_OFS_MASK, 32'h0000ffff); // all masked
        rdchk(`CDPIC_OFS_MCFG, 32'h00000008); // normal eoi, nesting off
        rdchk(`CDPIC_OFS_SCFG, 32'h00000070); // own base
        rdchk(`CDPIC_OFS_LVL, 32'h0); // all edge
        rdchk(`CDPIC_OFS_XBCFG, 32'h0); // apic and mouse off
        apb(1'b0, 8'h30, 32'h0);
        `CHECK_EQ({err, rd}, {1'b1, 32'h0})
        apb(1'b1, `CDPIC_OFS_MASK, 32'h0);
        apb(1'b1, `CDPIC_OFS_ICLR, 32'h7);
    endtask

    task automatic t_timer();
        @(posedge clock) extIrq[0] <= 1'b1;
        quiet(); // pin 0 unused without apic
        extIrq[0] <= 1'b0;
        @(posedge clock) timerIrq <= 1'b1;
        expv(8'h08, 2'h1); // timer on line 0
        timerIrq <= 1'b0;
        apb(1'b1, `CDPIC_OFS_XBCFG, 32'h1);
        @(posedge clock) extIrq[0] <= 1'b1;
        expv(8'h08, 2'h1); // pin 0 with apic
        extIrq[0] <= 1'b0;
        apb(1'b1, `CDPIC_OFS_XBCFG, 32'h0);
        apb(1'b1, `CDPIC_OFS_MCFG, 32'h20);
        @(posedge clock) timerIrq <= 1'b1;
        expv(8'h20, 2'h1); // master base moved alone
        timerIrq <= 1'b0;
        rdchk(`CDPIC_OFS_SCFG, 32'h70); // slave untouched
        apb(1'b1, `CDPIC_OFS_MCFG, 32'h08);
    endtask

    task automatic t_cascade();
        @(posedge clock) extIrq[2] <= 1'b1;
        quiet(); // cascade input not a user line
        extIrq[2] <= 1'b0;
        slow <= 1'b1;
        @(posedge clock) extIrq[9] <= 1'b1;
        expv(8'h71, 2'h3); // slave gives vector
        extIrq[9] <= 1'b0;
        // master in special nesting: a higher slave line passes an in-service one
        apb(1'b1, `CDPIC_OFS_MCFG, 32'h0a);
        @(posedge clock) extIrq[14] <= 1'b1;
        expv(8'h76, 2'h0); // upper group on slave, left in service
        extIrq[9] <= 1'b1;
        expv(8'h71, 2'h3); // nested slave line gets through
        apb(1'b1, `CDPIC_OFS_EOI, 32'h3);
        extIrq <= 16'h0;
        slow <= 1'b0;
        // master in auto eoi: nothing stays in service after the ack
        apb(1'b1, `CDPIC_OFS_MCFG, 32'h09);
        @(posedge clock) extIrq[3] <= 1'b1;
        expv(8'h0b, 2'h0); // lower group on master
        rdchk(`CDPIC_OFS_ISR, 32'h0); // auto eoi mode of the master alone
        extIrq[3] <= 1'b0;
        apb(1'b1, `CDPIC_OFS_MCFG, 32'h08);
    endtask

    task automatic t_fixed();
        @(posedge clock) extIrq[13] <= 1'b1;
        quiet(); // pin 13 unused
        extIrq[13] <= 1'b0;
        @(posedge clock) fpuErrIrq <= 1'b1;
        expv(8'h75, 2'h3); // coprocessor error
        fpuErrIrq <= 1'b0;
        @(posedge clock) extIrq[12] <= 1'b1;
        expv(8'h74, 2'h3); // pin 12 with mouse off
        extIrq[12] <= 1'b0;
        apb(1'b1, `CDPIC_OFS_XBCFG, 32'h10);
        @(posedge clock) extIrq[12] <= 1'b1;
        quiet(); // pin 12 cut off
        extIrq[12] <= 1'b0;
        @(posedge clock) mouseIrq <= 1'b1;
        expv(8'h74, 2'h3); // mouse drives line 12
        mouseIrq <= 1'b0;
        apb(1'b1, `CDPIC_OFS_XBCFG, 32'h0);
    endtask

    task automatic t_sense();
        apb(1'b1, `CDPIC_OFS_LVL, 32'hffff);
        rdchk(`CDPIC_OFS_LVL, 32'hdff8); // fixed lines stay edge
        @(posedge clock) extIrq[1] <= 1'b1;
        expv(8'h09, 2'h1);
        quiet(); // held line 1 served once
        extIrq[1] <= 1'b0;
        @(posedge clock) extIrq[5] <= 1'b1;
        expv(8'h0d, 2'h1);
        expv(8'h0d, 2'h0); // held level line served again
        extIrq[5] <= 1'b0;
        apb(1'b1, `CDPIC_OFS_EOI, 32'h1);
        apb(1'b1, `CDPIC_OFS_LVL, 32'h0);
    endtask

    // every target once, the four pins in turn; target 2 must be dropped
    task automatic t_steer();
        apb(1'b1, `CDPIC_OFS_STEER, 32'h8200);
        @(posedge clock) pciIrqN[1] <= 1'b0;
        quiet(); // bad target ignored
        pciIrqN[1] <= 1'b1;
        for (int k = 0; k < 11; k++)
        begin
            apb(1'b1, `CDPIC_OFS_STEER, (32'h80 | tgts[k]) << (8 * (k % 4)));
            pciIrqN[k % 4] <= 1'b0;
            expv((tgts[k] < 8 ? 8'h08 : 8'h70) | tgts[k][2:0], tgts[k] < 8 ? 2'h1 : 2'h3);
            pciIrqN[k % 4] <= 1'b1;
        end
        apb(1'b1, `CDPIC_OFS_STEER, 32'h0);
    endtask

    task automatic t_priority();
        ackEn <= 1'b0;
        @(posedge clock) extIrq[3] <= 1'b1;
        extIrq[1] <= 1'b1;
        extIrq[10] <= 1'b1;
        repeat (3) @(posedge clock);
        rdchk(`CDPIC_OFS_IRR, 32'h0000040e); // lines 1,2,3 and slave 10 waiting
        ackEn <= 1'b1;
        expv(8'h09, 2'h1); // lowest line first
        expv(8'h72, 2'h3); // slave ranks at 2
        expv(8'h0b, 2'h1);
        extIrq <= 16'h0;
    endtask

    task automatic t_irq();
        apb(1'b1, `CDPIC_OFS_ICLR, 32'h7);
        rdchk(`CDPIC_OFS_ISTAT, 32'h0);
        apb(1'b1, `CDPIC_OFS_IEN, 32'h2);
        @(posedge clock) timerIrq <= 1'b1;
        expv(8'h08, 2'h1);
        timerIrq <= 1'b0;
        rdchk(`CDPIC_OFS_ISTAT, 32'h1);
        `CHECK_EQ(irq, 1'b0)
        @(posedge clock) forceAck <= 1'b1;
        @(posedge clock) forceAck <= 1'b0;
        expv(8'h0f, 2'h0);
        rdchk(`CDPIC_OFS_ISTAT, 32'h3);
        `CHECK_EQ(irq, 1'b1)
        apb(1'b1, `CDPIC_OFS_ICLR, 32'h2);
        rdchk(`CDPIC_OFS_ISTAT, 32'h1);
        `CHECK_EQ(irq, 1'b0)
    endtask

    task automatic completeRun();
        $display("checks %0d errors %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog sized well above the whole sequence
    initial
    begin
        #(100 * 30000);
        badCount++;
        $display("ERROR t=%0t watchdog expired", $time);
        completeRun();
    end

    initial
    begin
        {rst_n, psel, penable, pwrite, timerIrq, fpuErrIrq, mouseIrq} = 7'h0;
        {forceAck, slow, paddr, pwdata, extIrq, seenCount} = '0;
        ackEn = 1'b1;
        pciIrqN = 4'hf;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset();
        t_timer();
        t_cascade();
        t_fixed();
        t_sense();
        t_steer();
        t_priority();
        t_irq();
        completeRun();
    end
endmodule
`default_nettype wire
